//--- trr_pkg.sv
// Package with constants and types for the touch report responder.
package trr_pkg;

  // Key and report geometry.
  localparam int          NKEY       = 11;
  localparam int          NIND       = 7;
  localparam int          NSETUP     = 42;
  localparam logic [5:0]  LEN_NONE   = 6'h00;
  localparam logic [5:0]  LEN_ONE    = 6'h01;
  localparam logic [5:0]  LEN_TWO    = 6'h02;
  localparam logic [5:0]  LEN_SETUP  = 6'h2A;

  // Request codes.
  localparam logic [7:0]  REQ_FIRST  = 8'hC0;
  localparam logic [7:0]  REQ_ALL    = 8'hC1;
  localparam logic [7:0]  REQ_STAT   = 8'hC2;
  localparam logic [7:0]  REQ_SCRC   = 8'hC3;
  localparam logic [7:0]  REQ_WCRC   = 8'hC4;
  localparam logic [7:0]  REQ_ERR    = 8'hC5;
  localparam logic [7:0]  REQ_IND    = 8'hC6;
  localparam logic [7:0]  REQ_LAST   = 8'hC7;
  localparam logic [7:0]  REQ_SETUP  = 8'hC8;
  localparam logic [7:0]  REQ_ID     = 8'hC9;
  localparam logic [7:0]  REQ_FW     = 8'hCA;
  localparam logic [3:0]  GRP_SIG    = 4'h2;
  localparam logic [3:0]  GRP_REF    = 4'h4;
  localparam logic [3:0]  GRP_KST    = 4'h8;
  localparam logic [3:0]  KEY_MAX    = 4'hA;

  // Arbitrary identification value, not tied to any real part.
  localparam logic [7:0]  DEV_ID     = 8'hA5;

  // Fixed maximum burst limit in pulses.
  localparam logic [15:0] MAX_BURST  = 16'h0800;

  // Abandon timeout: 100 ms at 250 MHz.
  localparam int          TMO_MS     = 100;
  localparam int          CLK_KHZ    = 250000;
  localparam int          TMO_CYC    = TMO_MS * CLK_KHZ;

  // Register byte offsets.
  localparam logic [7:0]  A_CTRL     = 8'h00;
  localparam logic [7:0]  A_TOUCH    = 8'h04;
  localparam logic [7:0]  A_KEYEN    = 8'h08;
  localparam logic [7:0]  A_NSUP     = 8'h0C;
  localparam logic [7:0]  A_TRIM     = 8'h10;
  localparam logic [7:0]  A_IND      = 8'h14;
  localparam logic [7:0]  A_CRC      = 8'h18;
  localparam logic [7:0]  A_FW       = 8'h1C;
  localparam logic [7:0]  A_SIG      = 8'h20;
  localparam logic [7:0]  A_REF      = 8'h24;
  localparam logic [7:0]  A_SETUP    = 8'h28;
  localparam logic [7:0]  A_CYCLE    = 8'h2C;
  localparam logic [7:0]  A_LBL      = 8'h30;
  localparam logic [7:0]  A_STAT     = 8'h34;

  // Control register fields.
  localparam int          C_SHEN     = 0;
  localparam int          C_SHACT    = 1;
  localparam int          C_STVAL    = 2;
  localparam int          C_ATTN     = 3;

  // Status byte fields.
  localparam int          S_ONE      = 7;
  localparam int          S_TOUCH    = 6;
  localparam int          S_OVR      = 5;
  localparam int          S_ERR      = 4;
  localparam int          S_ATTN     = 3;
  localparam int          S_STORE    = 2;
  localparam int          S_RST      = 1;
  localparam int          S_SHIELD   = 0;

  // Wishbone request from the master.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } trr_wb_req_t;

  // Serial link inputs from pins.
  typedef struct packed {
    logic sclk;
    logic ss_n;
    logic mosi;
  } trr_spi_in_t;

endpackage

//--- trr_responder.sv
// Report request responder: serial slave plus Wishbone register file.
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module trr_responder #(
  parameter int TMO_CYCLES = trr_pkg::TMO_CYC
) (
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave.
  input  wire trr_pkg::trr_wb_req_t wb_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // Serial link.
  input  wire trr_pkg::trr_spi_in_t spi_i,
  output logic                      miso_o,
  output logic                      miso_oe_n_o
);
  import trr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Register file.
  logic [4:0]        ctrl_ff;
  logic [NKEY-1:0]   touch_ff;
  logic [NKEY-1:0]   keyen_ff;
  logic [NKEY-1:0]   nsup_ff;
  logic [NKEY-1:0]   trim_ff;
  logic [NIND-1:0]   ind_ff;
  logic [15:0]       crc_ff;
  logic [7:0]        fw_ff;
  logic [31:0]       cycle_ff;
  logic [15:0]       lbl_ff;
  logic [15:0]       sig_mem [NKEY];
  logic [15:0]       ref_mem [NKEY];
  logic [7:0]        setup_mem [NSETUP];
  logic              wb_wr;
  logic [7:0]        last_cmd_ff;
  logic [3:0]        first_ff;
  logic              rst_flag_ff;
  logic [5:0]        pend_ff;
  logic              multi;

  // A write lands on the edge at which the master samples ack high.
  assign wb_wr = wb_i.cyc && wb_i.stb && wb_i.we && wb_ack_o;

  // Scalar configuration registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff  <= 5'h00;
      touch_ff <= '0;
      keyen_ff <= '0;
      nsup_ff  <= '0;
      trim_ff  <= '0;
      ind_ff   <= '0;
      crc_ff   <= 16'h0000;
      fw_ff    <= 8'h00;
      cycle_ff <= 32'h0000_0000;
      lbl_ff   <= 16'h0000;
    end else if (wb_wr) begin
      unique case (wb_i.adr)
        A_CTRL:  ctrl_ff  <= wb_i.dat[4:0];
        A_TOUCH: touch_ff <= wb_i.dat[NKEY-1:0];
        A_KEYEN: keyen_ff <= wb_i.dat[NKEY-1:0];
        A_NSUP:  nsup_ff  <= wb_i.dat[NKEY-1:0];
        A_TRIM:  trim_ff  <= wb_i.dat[NKEY-1:0];
        A_IND:   ind_ff   <= wb_i.dat[NIND-1:0]; // Destination states.
        A_CRC:   crc_ff   <= wb_i.dat[15:0];
        A_FW:    fw_ff    <= wb_i.dat[7:0];
        A_CYCLE: cycle_ff <= wb_i.dat;
        A_LBL:   lbl_ff   <= wb_i.dat[15:0];
        default: ;
      endcase
    end
  end

  // Per key measurement arrays and the setup table, written indirectly.
  always_ff @(posedge clk_i) begin
    if (wb_wr && wb_i.adr == A_SIG && wb_i.dat[19:16] <= KEY_MAX) begin
      sig_mem[wb_i.dat[19:16]] <= wb_i.dat[15:0];
    end
    if (wb_wr && wb_i.adr == A_REF && wb_i.dat[19:16] <= KEY_MAX) begin
      ref_mem[wb_i.dat[19:16]] <= wb_i.dat[15:0];
    end
    if (wb_wr && wb_i.adr == A_SETUP && wb_i.dat[13:8] < LEN_SETUP) begin
      setup_mem[wb_i.dat[13:8]] <= wb_i.dat[7:0];
    end
  end

  // Bus answer: one wait state, unmapped reads return zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_i.cyc && wb_i.stb && !wb_ack_o;
      unique case (wb_i.adr)
        A_CTRL:  wb_dat_o <= {27'h0, ctrl_ff};
        A_TOUCH: wb_dat_o <= {21'h0, touch_ff};
        A_KEYEN: wb_dat_o <= {21'h0, keyen_ff};
        A_NSUP:  wb_dat_o <= {21'h0, nsup_ff};
        A_TRIM:  wb_dat_o <= {21'h0, trim_ff};
        A_IND:   wb_dat_o <= {25'h0, ind_ff};
        A_CRC:   wb_dat_o <= {16'h0, crc_ff};
        A_FW:    wb_dat_o <= {24'h0, fw_ff};
        A_CYCLE: wb_dat_o <= cycle_ff;
        A_LBL:   wb_dat_o <= {16'h0, lbl_ff};
        A_STAT:  wb_dat_o <= {12'h000, pend_ff, multi, rst_flag_ff, first_ff, last_cmd_ff};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Derived key state.
  logic [NKEY-1:0] lbf;
  logic [NKEY-1:0] mbf;
  logic [NKEY-1:0] errk;
  logic            overrun;
  logic            shield;
  logic [7:0]      status_byte;

  // Burst faults per key; disabled keys never report an error.
  always_comb begin
    for (int k = 0; k < NKEY; k++) begin
      mbf[k]  = sig_mem[k] >= MAX_BURST;
      lbf[k]  = sig_mem[k] < lbl_ff;
      errk[k] = keyen_ff[k] && (mbf[k] || lbf[k]);
    end
  end

  // Overrun while measured time exceeds configured cycle time.
  assign overrun = cycle_ff[31:16] > cycle_ff[15:0];
  assign shield  = ctrl_ff[C_SHEN] && ctrl_ff[C_SHACT];
  assign multi   = !$onehot0(touch_ff);

  // Device status byte.
  always_comb begin
    status_byte           = 8'h00;
    status_byte[S_ONE]    = 1'b1;
    status_byte[S_TOUCH]  = |touch_ff;
    status_byte[S_OVR]    = overrun;
    status_byte[S_ERR]    = |errk;
    status_byte[S_ATTN]   = ctrl_ff[C_ATTN];
    status_byte[S_STORE]  = !ctrl_ff[C_STVAL];
    status_byte[S_RST]    = rst_flag_ff;
    status_byte[S_SHIELD] = shield;
  end

  // Earliest touched key is held until released, then lowest touched wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_ff <= 4'h0;
    end else if (!touch_ff[first_ff] || first_ff > KEY_MAX) begin
      for (int k = NKEY - 1; k >= 0; k--) begin
        if (touch_ff[k]) begin
          first_ff <= 4'(k);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link input synchronisers and edge detection.
  logic [2:0] sy1_ff;
  logic [2:0] sy2_ff;
  logic       sclk_d_ff;
  logic       rise;
  logic       fall;
  logic       sel;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sy1_ff      <= 3'h2;
      sy2_ff      <= 3'h2;
      sclk_d_ff   <= 1'b0;
      miso_oe_n_o <= 1'b1;
    end else begin
      sy1_ff      <= {spi_i.sclk, spi_i.ss_n, spi_i.mosi};
      sy2_ff      <= sy1_ff;
      sclk_d_ff   <= sy2_ff[2];
      miso_oe_n_o <= sy2_ff[1];                         // Driven only while selected.
    end
  end

  assign sel  = !sy2_ff[1];
  assign rise = sel && sy2_ff[2] && !sclk_d_ff;
  assign fall = sel && !sy2_ff[2] && sclk_d_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Byte engine and request decode.
  logic [2:0]  bit_ff;
  logic [7:0]  rx_ff;
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic        load_ff;
  logic [7:0]  cmd_ff;
  logic [5:0]  idx_ff;
  logic [24:0] tmo_ff;
  logic        tmo;
  logic        cmd_evt;
  logic [5:0]  req_len;
  logic [7:0]  rsp_byte;
  logic [7:0]  tx_ff;
  logic [3:0]  rk;
  logic [3:0]  ck;
  logic        tx_load;

  assign rx_byte   = {rx_ff[6:0], sy2_ff[0]};
  assign byte_done = rise && bit_ff == 3'h7;
  assign cmd_evt   = byte_done && pend_ff == LEN_NONE;
  assign tmo       = tmo_ff == 25'(TMO_CYCLES - 1);
  assign rk        = rx_byte[3:0];

  // Abandon timer counts only mid-exchange and restarts on each serial clock edge.
  always_ff @(posedge clk_i) begin
    if (rst_i || rise || fall || (bit_ff == 3'h0 && pend_ff == LEN_NONE) || tmo) begin
      tmo_ff <= 25'h0;
    end else begin
      tmo_ff <= tmo_ff + 25'h1;
    end
  end

  // Bit counter and receive shifter, MSB first.
  always_ff @(posedge clk_i) begin
    if (rst_i || !sel || tmo) begin
      bit_ff <= 3'h0;
      rx_ff  <= 8'h00;
    end else if (rise) begin
      bit_ff <= bit_ff + 3'h1;
      rx_ff  <= rx_byte;
    end
  end

  // Length of the reply for a received request code.
  always_comb begin
    req_len = LEN_NONE;
    unique case (rx_byte[7:4])
      GRP_SIG, GRP_REF: req_len = (rk <= KEY_MAX) ? LEN_TWO : LEN_NONE;
      GRP_KST:          req_len = (rk <= KEY_MAX) ? LEN_ONE : LEN_NONE;
      REQ_FIRST[7:4]: begin
        if (rx_byte == REQ_ALL || rx_byte == REQ_ERR) begin
          req_len = LEN_TWO;
        end else if (rx_byte == REQ_SETUP) begin
          req_len = LEN_SETUP;
        end else if (rx_byte <= REQ_FW) begin
          req_len = LEN_ONE;
        end
      end
      default: req_len = LEN_NONE;
    endcase
  end

  // Exchange state: command latch, bytes still owed, byte load strobe.
  always_ff @(posedge clk_i) begin
    if (rst_i || tmo) begin
      pend_ff <= LEN_NONE;
      cmd_ff  <= 8'h00;
      load_ff <= 1'b0;
    end else begin
      load_ff <= byte_done;
      if (cmd_evt) begin
        cmd_ff  <= rx_byte;
        pend_ff <= req_len;
      end else if (byte_done) begin
        pend_ff <= pend_ff - 6'h01;                       // One filler per byte.
      end
    end
  end

  // Reply index advances at each byte load.
  always_ff @(posedge clk_i) begin
    if (rst_i || cmd_evt) begin
      idx_ff <= 6'h00;
    end else if (tx_load) begin
      idx_ff <= idx_ff + 6'h01;
    end
  end

  // Last command history, excluding its own request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_cmd_ff <= 8'h00;
    end else if (cmd_evt && rx_byte != REQ_LAST) begin
      last_cmd_ff <= rx_byte;
    end
  end

  // Reset flag: cleared as the status reply is loaded, so that reply still shows it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_flag_ff <= 1'b1;
    end else if (tx_load && cmd_ff == REQ_STAT) begin
      rst_flag_ff <= 1'b0;
    end
  end

  // Reply byte for the latched command and the current index.
  assign ck = cmd_ff[3:0];
  always_comb begin
    rsp_byte = 8'h00;
    unique case (cmd_ff[7:4])
      GRP_SIG: rsp_byte = (idx_ff == 6'h00) ? sig_mem[ck][15:8] : sig_mem[ck][7:0];
      GRP_REF: rsp_byte = (idx_ff == 6'h00) ? ref_mem[ck][15:8] : ref_mem[ck][7:0];
      GRP_KST: rsp_byte = {touch_ff[ck], lbf[ck], mbf[ck], 2'b00,
                           nsup_ff[ck], trim_ff[ck], keyen_ff[ck]};
      default: begin
        unique case (cmd_ff)
          REQ_FIRST: rsp_byte = {|touch_ff, multi, |errk, 1'b0, first_ff};
          REQ_ALL:   rsp_byte = (idx_ff == 6'h00) ? {5'h00, touch_ff[10:8]}
                                                  : touch_ff[7:0];
          REQ_STAT:  rsp_byte = status_byte;
          REQ_SCRC:  rsp_byte = ctrl_ff[C_STVAL] ? crc_ff[7:0] : 8'h00;
          REQ_WCRC:  rsp_byte = crc_ff[15:8];
          REQ_ERR:   rsp_byte = (idx_ff == 6'h00) ? {5'h00, errk[10:8]}
                                                  : errk[7:0];
          REQ_IND:   rsp_byte = {1'b0, ind_ff};
          REQ_LAST:  rsp_byte = last_cmd_ff;
          REQ_SETUP: rsp_byte = setup_mem[idx_ff];
          REQ_ID:    rsp_byte = DEV_ID;
          REQ_FW:    rsp_byte = fw_ff;
          default:   rsp_byte = 8'h00;
        endcase
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit shifter: new byte one cycle after the eighth rising edge.
  assign tx_load = load_ff && pend_ff != LEN_NONE && sel;

  always_ff @(posedge clk_i) begin
    if (rst_i || !sel || tmo) begin
      tx_ff  <= 8'h00;
      miso_o <= 1'b0;
    end else if (load_ff) begin
      tx_ff  <= tx_load ? rsp_byte : 8'h00;               // Sent MSB first.
      miso_o <= tx_load ? rsp_byte[7] : 1'b0;
    end else if (fall && bit_ff != 3'h0) begin
      tx_ff  <= {tx_ff[6:0], 1'b0};
      miso_o <= tx_ff[6];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  rst_flag_clr_a: assert property (tx_load && cmd_ff == REQ_STAT |=> !rst_flag_ff)
    else $error("reset flag not cleared by status request");
  last_cmd_a: assert property (cmd_evt && rx_byte != REQ_LAST |=> last_cmd_ff == $past(rx_byte))
    else $error("last command not recorded");
  last_keep_a: assert property (cmd_evt && rx_byte == REQ_LAST |=> $stable(last_cmd_ff))
    else $error("last command overwritten by its own request");
  timeout_clr_a: assert property (tmo |=> pend_ff == LEN_NONE && bit_ff == 3'h0)
    else $error("exchange not abandoned on timeout");
  store_crc_a: assert property (cmd_ff == REQ_SCRC && !ctrl_ff[C_STVAL] |-> rsp_byte == 8'h00)
    else $error("stored checksum not zero without stored setup");
  shield_off_a: assert property (!ctrl_ff[C_SHEN] |-> !status_byte[S_SHIELD])
    else $error("shield bit set while shield disabled");
  err_masked_a: assert property ((errk & ~keyen_ff) == '0)
    else $error("disabled key reports error");
  reply_len_a: assert property (cmd_evt && rx_byte == REQ_SETUP |=> pend_ff == LEN_SETUP)
    else $error("setup reply length wrong");
  stat_one_a: assert property (cmd_ff == REQ_STAT |-> rsp_byte[S_ONE])
    else $error("status bit 7 not one");
  tx_load_a: assert property (byte_done && pend_ff == LEN_NONE && req_len != LEN_NONE && sel
                              |=> ##1 miso_o == $past(rsp_byte[7]))
    else $error("first reply bit not presented");

endmodule
`default_nettype wire

//--- trr_host_model.sv
// Host side serial master model that talks to the report responder.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module trr_host_model (
  // Line from the device.
  input  wire logic                miso_i,
  // Pins toward the device.
  output var  trr_pkg::trr_spi_in_t spi_o
);
  import trr_pkg::*;

  logic [7:0] rbuf [0:41];

  // The link clock stands low and the device is released at time zero.
  initial spi_o = '{sclk: 1'b0, ss_n: 1'b1, mosi: 1'b0};

  // Selects or releases the device, then lets its synchroniser settle.
  task automatic sel(input logic on);
    spi_o.ss_n = ~on;
    #100;
  endtask

  // Shifts one byte each way in mode 0 with a 125 ns link period.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_o.mosi = tx[i];
      #62.5;
      spi_o.sclk = 1'b1;
      rx[i] = miso_i;
      #62.5;
      spi_o.sclk = 1'b0;
    end
  endtask

  // Sends a request and clocks the reply out with null filler bytes.
  task automatic req(input logic [7:0] cmd, input int n);
    logic [7:0] d;
    sel(1'b1);
    xfer(cmd, d);
    for (int i = 0; i < n; i++) xfer(8'h00, rbuf[i]);
    sel(1'b0);
  endtask
endmodule
`default_nettype wire

//--- touch_report_responder_tb.sv
// Self-checking testbench for the touch report responder.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module touch_report_responder_tb;
  import trr_pkg::*;

  localparam int TMO = 2000;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  trr_wb_req_t wb = '0;
  logic [31:0] wb_dat;
  logic        wb_ack;
  logic        miso;
  logic        miso_oe_n;
  logic        miso_w;
  logic        idle_t = 1'b0;
  trr_spi_in_t spi;
  logic [31:0] q;
  logic [7:0]  d8;
  int          err_count = 0;
  int          cmp_count = 0;

  // Clock, and a released data line that shows a pattern changing every cycle.
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) idle_t <= ~idle_t;
  assign miso_w = miso_oe_n ? idle_t : miso;

  ////////////////////////////////////////////////////////////////////////////////
  // Device under test and the host that sits on its serial link.
  trr_responder #(.TMO_CYCLES(TMO)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
    .spi_i(spi), .miso_o(miso), .miso_oe_n_o(miso_oe_n));
  trr_host_model host (.miso_i(miso_w), .spi_o(spi));

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One classic Wishbone cycle; read data is taken at the acknowledging edge.
  task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_dat;
    wb <= '0;
    if (wb_ack !== 1'b1) begin
      err_count++;
      $display("FAIL t=%0t ack=%h exp=%h", $time, wb_ack, 1'b1);
      summarize();
    end
  endtask

  // Register write, and masked register read with comparison.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  // Report request with a one or two byte reply, high byte first.
  task automatic rq(input logic [7:0] c, input int n, input logic [15:0] e);
    host.req(c, n);
    chk(n == 1 ? {24'h0, host.rbuf[0]} : {16'h0, host.rbuf[0], host.rbuf[1]}, {16'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rq(REQ_STAT, 1, 16'h0086);
    rq(REQ_STAT, 1, 16'h0084);
    wr(A_CRC, 32'h0000_3C5A);
    rq(REQ_SCRC, 1, 16'h0000);
    rq(REQ_WCRC, 1, 16'h003C);
    for (int k = 0; k < NKEY; k++) wr(A_SIG, {12'h000, 4'(k), 16'h0400});
    for (int a = 0; a < NSETUP; a++) wr(A_SETUP, {18'h0, 6'(a), 8'h30 + 8'(a)});
    wr(A_KEYEN, 32'h7FF);
    wr(A_SIG, 32'h0005_07E5);
    wr(A_REF, 32'h000A_BEEF);
    rq({GRP_SIG, 4'h5}, 2, 16'h07E5);
    rq({GRP_REF, KEY_MAX}, 2, 16'hBEEF);
    wr(A_CTRL, 32'hF);
    wr(A_CYCLE, 32'h0200_0100);
    rq(REQ_STAT, 1, 16'h00A9);
    rq(REQ_SCRC, 1, 16'h005A);
    wr(A_CTRL, 32'hE);
    wr(A_CYCLE, 32'h0100_0100);
    rq(REQ_STAT, 1, 16'h0088);
    wr(A_TOUCH, 32'h008);
    rq(REQ_FIRST, 1, 16'h0083);
    wr(A_TOUCH, 32'h408);
    rq(REQ_FIRST, 1, 16'h00C3);
    rq(REQ_ALL, 2, 16'h0408);
    // Key 2 at the maximum burst limit, key 7 below the lower limit.
    wr(A_SIG, 32'h0002_0800);
    wr(A_SIG, 32'h0007_0050);
    wr(A_LBL, 32'h100);
    wr(A_NSUP, 32'h4);
    wr(A_TRIM, 32'h4);
    rq(REQ_ERR, 2, 16'h0084);
    rq({GRP_KST, 4'h2}, 1, 16'h0027);
    rq({GRP_KST, 4'h7}, 1, 16'h0041);
    rq({GRP_KST, 4'h3}, 1, 16'h0081);
    rq(REQ_FIRST, 1, 16'h00E3);
    wr(A_KEYEN, 32'h77B);
    rq(REQ_ERR, 2, 16'h0000);
    wr(A_IND, 32'h55);
    rq(REQ_IND, 1, 16'h0055);
    wr(A_IND, 32'h2A);
    rq(REQ_IND, 1, 16'h002A);
    wr(A_FW, 32'h37);
    rq(REQ_FW, 1, 16'h0037);
    rq(REQ_ID, 1, {8'h00, DEV_ID});
    rq(REQ_LAST, 1, 16'h00C9);
    rq(REQ_LAST, 1, 16'h00C9);
    host.req(REQ_SETUP, NSETUP);
    for (int a = 0; a < NSETUP; a++) chk({24'h0, host.rbuf[a]}, {24'h0, 8'h30 + 8'(a)});
    rdc(A_STAT, 32'hFF, {24'h0, REQ_SETUP});
    rdc(A_KEYEN, 32'h7FF, 32'h77B);
    rdc(8'h3C, 32'hFFFF_FFFF, 32'h0);
    // A request left hanging past the idle limit must be dropped.
    host.sel(1'b1);
    host.xfer(REQ_ALL, d8);
    repeat (TMO + 200) @(posedge clk_i);
    host.xfer(REQ_ID, d8);
    host.xfer(8'h00, d8);
    host.sel(1'b0);
    chk({24'h0, d8}, {24'h0, DEV_ID});
    summarize();
  end
endmodule
`default_nettype wire
